// ===== rtl/mfs_defs.svh
// constants of the motor starter fault supervisor
`ifndef MFS_DEFS_SVH
`define MFS_DEFS_SVH

// clock and timebase
`define MFS_CLK_NS      10
`define MFS_TICK_NS     1000000
// times in milliseconds
`define MFS_OC_MS       11'd1000
`define MFS_AUTO_MS     11'd1000
`define MFS_FLASH_MS    10'd250
`define MFS_GAP_MS      10'd1000
`define MFS_S_TO_MS     18'd1000

// thresholds, currents in 0.1 A, frequency in 0.1 Hz, supply in Vac
`define MFS_SC_PCT      24'd30
`define MFS_FULL_PCT    24'd100
`define MFS_UV_VAC      9'd93
`define MFS_F_LO        10'd450
`define MFS_F_HI        10'd660
`define MFS_PB_LIM0     16'd375
`define MFS_PB_LIM1     16'd2000
`define MFS_PB_LIM2     16'd2600
`define MFS_PB_LIM3     16'd4000
`define MFS_PB_LIM4     16'd8240

// register offsets
`define MFS_REG_STATUS  4'h0
`define MFS_REG_MASK    4'h4
`define MFS_REG_CODE    4'h8
`define MFS_REG_CTRL    4'hc

// fault bit positions in status, mask and detect vectors; MFS_B_SWBLK is the block bit of the control register
`define MFS_NFLT        11
`define MFS_B_OVL       0
`define MFS_B_SC        1
`define MFS_B_STO       2
`define MFS_B_STALL     3
`define MFS_B_OC        4
`define MFS_B_SEQ       5
`define MFS_B_UV        6
`define MFS_B_BYP       7
`define MFS_B_PBOC      8
`define MFS_B_FREQ      9
`define MFS_B_SHORT     10
`define MFS_B_SWBLK     0

// reset values
`define MFS_MASK_RST    11'h000
`define MFS_CTRL_RST    1'b0

`endif

// ===== rtl/mfs_pkg.sv
// types of the motor starter fault supervisor
package mfs_pkg;
   // starting state reported by the starter sequencer
   typedef enum logic [1:0] {
      MFS_RUN_STOP   = 2'b00,
      MFS_RUN_RAMP   = 2'b01,
      MFS_RUN_PREBYP = 2'b11,
      MFS_RUN_FULL   = 2'b10
   } mfs_run_e;

   // supervisor state
   typedef enum logic [1:0] {
      MFS_SV_INIT = 2'b00,
      MFS_SV_MON  = 2'b01,
      MFS_SV_TRIP = 2'b11
   } mfs_sv_e;

   // latched fault code
   typedef enum logic [7:0] {
      MFS_F_NONE  = 8'h00,
      MFS_F_OVL   = 8'h05,
      MFS_F_SC    = 8'h13,
      MFS_F_STO   = 8'h3e,
      MFS_F_STALL = 8'h3f,
      MFS_F_OC    = 8'h42,
      MFS_F_SEQ   = 8'h43,
      MFS_F_UV    = 8'h46,
      MFS_F_BYP   = 8'h47,
      MFS_F_PBOC  = 8'h48,
      MFS_F_FREQ  = 8'h4b,
      MFS_F_SHORT = 8'h4d
   } mfs_code_e;
endpackage

// ===== rtl/mfs_led_if.sv
// link between the supervisor and its led pattern generator
interface mfs_led_if;
   import mfs_pkg::*;
   logic      tick;
   logic      tripped;
   logic      ready;
   mfs_code_e code;
   logic      fault_led;
   logic      ready_led;
   logic      overload_led;
   logic      stall_led;
   logic      overcurrent_led;
   logic      phase_seq_led;
   modport sup (output tick, tripped, ready, code,
                input  fault_led, ready_led, overload_led, stall_led,
                       overcurrent_led, phase_seq_led);
   modport led (input  tick, tripped, ready, code,
                output fault_led, ready_led, overload_led, stall_led,
                       overcurrent_led, phase_seq_led);
endinterface

// ===== rtl/mfs_led.sv
// led flash pattern generator of the fault supervisor
`include "mfs_defs.svh"
module mfs_led
   import mfs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // supervisor side
   mfs_led_if.led   lk
);
   logic       ded;
   logic [2:0] n;
   logic       on_q;
   logic       gap_q;
   logic [9:0] ms_q;
   logic [2:0] nfl_q;
   logic       fault_led_q;
   logic       ready_led_q;
   logic       ovl_q;
   logic       stall_q;
   logic       oc_q;
   logic       seq_q;

   // faults with their own led flash it without a count
   always_comb begin
      ded = 1'b0;
      n   = 3'd1;
      case (lk.code)
         MFS_F_OVL, MFS_F_STALL, MFS_F_OC, MFS_F_SEQ: ded = 1'b1;
         MFS_F_SC:    n = 3'd7;
         MFS_F_STO:   n = 3'd2;
         MFS_F_UV:    n = 3'd2;
         MFS_F_BYP:   n = 3'd3;
         MFS_F_PBOC:  n = 3'd4;
         MFS_F_SHORT: n = 3'd6;
         default:     n = 3'd1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset || !lk.tripped) begin
         on_q  <= 1'b0;
         gap_q <= 1'b0;
         ms_q  <= 10'h000;
         nfl_q <= 3'h0;
      end else if (lk.tick) begin
         if (gap_q) begin
            if (ms_q == `MFS_GAP_MS - 10'd1) begin
               gap_q <= 1'b0;
               ms_q  <= 10'h000;
            end else begin
               ms_q <= ms_q + 10'd1;
            end
         end else if (ms_q == `MFS_FLASH_MS - 10'd1) begin
            ms_q <= 10'h000;
            on_q <= ~on_q;
            if (on_q && !ded) begin
               if (nfl_q + 3'd1 == n) begin
                  gap_q <= 1'b1;
                  nfl_q <= 3'h0;
               end else begin
                  nfl_q <= nfl_q + 3'd1;
               end
            end
         end else begin
            ms_q <= ms_q + 10'd1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_led_q <= 1'b0;
         ready_led_q <= 1'b0;
         ovl_q       <= 1'b0;
         stall_q     <= 1'b0;
         oc_q        <= 1'b0;
         seq_q       <= 1'b0;
      end else begin
         fault_led_q <= lk.tripped & ~ded & on_q;
         ready_led_q <= lk.ready | (lk.tripped & (lk.code == MFS_F_STO));
         ovl_q       <= lk.tripped & on_q & (lk.code == MFS_F_OVL);
         stall_q     <= lk.tripped & on_q & (lk.code == MFS_F_STALL);
         oc_q        <= lk.tripped & on_q & (lk.code == MFS_F_OC);
         seq_q       <= lk.tripped & on_q & (lk.code == MFS_F_SEQ);
      end
   end

   assign lk.fault_led       = fault_led_q;
   assign lk.ready_led       = ready_led_q;
   assign lk.overload_led    = ovl_q;
   assign lk.stall_led       = stall_q;
   assign lk.overcurrent_led = oc_q;
   assign lk.phase_seq_led   = seq_q;
endmodule

// ===== rtl/mfs_supervisor.sv
// motor starter fault supervisor top
// What this block does
// - Overload fault when thermal accumulator passes class limit; any reset clears.
// - Thermal state saved at control power loss, restored at power return.
// - No run command and phase current above 30% rated: short fault, no auto unless a status bit of a fault that allows it is also set.
// - Current-limit start lasting past ramp time: start timeout fault.
// - Before full voltage, current above twice motor setting: stall fault.
// - At full voltage, current above twice setting over 1 s: overcurrent.
// - Synchronism interruptions out of first-second-third order: sequence fault.
// - Control supply below 93 Vac: undervoltage fault, auto reset allowed.
// - At full voltage, bypass contact failure: bypass open fault.
// - During ramp, current above model threshold: pre-bypass overcurrent.
// - Line frequency outside 45 to 66 Hz: frequency fault.
// - At switch-off with no input-output voltage difference: short fault.
// - Any fault blocks the starter and flashes leds until reset.
// - Clear by power-on, reset key, enabled auto reset, or reset input.
`include "mfs_defs.svh"
module mfs_supervisor
   import mfs_pkg::*;
#(
   parameter logic [16:0] TICK_CYC = 17'(`MFS_TICK_NS / `MFS_CLK_NS),
   parameter logic [31:0] OVL_K    = 32'd100000
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wr_data,
   input  wire logic        wr_en,
   input  wire logic        rd_en,
   output logic      [31:0] rd_data,
   output logic             irq,
   // pins, asynchronous
   input  wire logic        reset_key,
   input  wire logic        programmable_reset_input,
   input  wire logic        auto_reset_sw,
   input  wire logic        run_cmd,
   input  wire logic        sync_r,
   input  wire logic        sync_s,
   input  wire logic        sync_t,
   input  wire logic        ctrl_power_ok,
   // measurements and settings, same clock
   input  wire logic [15:0] i_phase_r,
   input  wire logic [15:0] i_phase_s,
   input  wire logic [15:0] i_phase_t,
   input  wire logic [15:0] i_rated,
   input  wire logic [15:0] i_motor_set,
   input  wire logic [2:0]  model_sel,
   input  wire logic [4:0]  thermal_class,
   input  wire logic [7:0]  ramp_time_s,
   input  wire logic        current_limit_mode,
   input  mfs_run_e         run_state,
   input  wire logic [8:0]  ctrl_supply_vac,
   input  wire logic [9:0]  line_freq,
   input  wire logic        bypass_fail,
   input  wire logic        no_volt_diff,
   // thermal state store
   output logic             nv_wr_en,
   output logic      [31:0] nv_wr_data,
   input  wire logic [31:0] nv_rd_data,
   input  wire logic        nv_rd_valid,
   // starter and indication
   output logic             starter_enable,
   output logic      [7:0]  fault_code,
   output logic             fault_led,
   output logic             ready_led,
   output logic             overload_led,
   output logic             stall_led,
   output logic             overcurrent_led,
   output logic             phase_seq_led
);
   localparam int NF = `MFS_NFLT;
   localparam logic [NF-1:0] AUTO_OK = 11'b01111011101;

   mfs_led_if lk ();

   logic [7:0]    s1_q, s2_q, s3_q;
   logic [16:0]   div_q;
   logic          tick;
   mfs_sv_e       sv_q;
   mfs_code_e     code_q, code_d;
   logic [NF-1:0] det, sts_q, mask_q;
   logic          swblk_q;
   logic [31:0]   acc_q;
   logic [10:0]   oc_ms_q;
   logic [17:0]   ramp_ms_q;
   logic [10:0]   auto_ms_q;
   logic [1:0]    last_q;
   logic          last_v_q;
   logic [15:0]   imax, pb_lim;
   logic          over2, sc_over, seq_err, clr;
   logic          key_rise, prog_rise, run_fall, pwr_fall;
   logic [2:0]    ph_ev;

   // two flip-flop synchronisers, third stage only for edges
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_q <= 8'h00;
         s2_q <= 8'h00;
         s3_q <= 8'h00;
      end else begin
         s1_q <= {ctrl_power_ok, sync_t, sync_s, sync_r, run_cmd,
                  auto_reset_sw, programmable_reset_input, reset_key};
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end
   assign key_rise  = s2_q[0] & ~s3_q[0];
   assign prog_rise = s2_q[1] & ~s3_q[1];
   assign run_fall  = ~s2_q[3] & s3_q[3];
   assign ph_ev     = s2_q[6:4] & ~s3_q[6:4];
   assign pwr_fall  = ~s2_q[7] & s3_q[7];

   // millisecond tick
   always_ff @(posedge clk) begin
      if (reset || div_q == TICK_CYC - 17'd1) begin
         div_q <= 17'h00000;
      end else begin
         div_q <= div_q + 17'd1;
      end
   end
   assign tick = (div_q == TICK_CYC - 17'd1);

   always_comb begin
      imax = (i_phase_r > i_phase_s) ? i_phase_r : i_phase_s;
      imax = (i_phase_t > imax) ? i_phase_t : imax;
      case (model_sel)
         3'd0:    pb_lim = `MFS_PB_LIM0;
         3'd1:    pb_lim = `MFS_PB_LIM1;
         3'd2:    pb_lim = `MFS_PB_LIM2;
         3'd3:    pb_lim = `MFS_PB_LIM3;
         default: pb_lim = `MFS_PB_LIM4;
      endcase
   end
   assign over2   = {1'b0, imax} > {i_motor_set, 1'b0};
   assign sc_over = 24'(imax) * `MFS_FULL_PCT > 24'(i_rated) * `MFS_SC_PCT;

   // thermal accumulator, a plain excess integrator with unit decay
   always_ff @(posedge clk) begin
      if (reset) begin
         acc_q <= 32'h00000000;
      end else if (sv_q == MFS_SV_INIT && nv_rd_valid) begin
         acc_q <= nv_rd_data;
      end else if (tick && imax > i_motor_set) begin
         acc_q <= acc_q + 32'(imax - i_motor_set);
      end else if (tick && acc_q != 32'h00000000) begin
         acc_q <= acc_q - 32'd1;
      end
   end

   // save on the falling edge of control power, before the rail dies
   always_ff @(posedge clk) begin
      if (reset) begin
         nv_wr_en   <= 1'b0;
         nv_wr_data <= 32'h00000000;
      end else begin
         nv_wr_en <= pwr_fall;
         if (pwr_fall) begin
            nv_wr_data <= acc_q;
         end
      end
   end

   // timers
   always_ff @(posedge clk) begin
      if (reset || run_state != MFS_RUN_FULL || !over2) begin
         oc_ms_q <= 11'h000;
      end else if (tick && oc_ms_q <= `MFS_OC_MS) begin
         oc_ms_q <= oc_ms_q + 11'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || run_state != MFS_RUN_RAMP || !current_limit_mode) begin
         ramp_ms_q <= 18'h00000;
      end else if (tick && ramp_ms_q != 18'h3ffff) begin
         ramp_ms_q <= ramp_ms_q + 18'd1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset || sv_q != MFS_SV_TRIP) begin
         auto_ms_q <= 11'h000;
      end else if (tick && auto_ms_q != `MFS_AUTO_MS) begin
         auto_ms_q <= auto_ms_q + 11'd1;
      end
   end

   // phase order tracking r, s, t
   always_comb begin
      seq_err = 1'b0;
      if (last_v_q) begin
         case (last_q)
            2'd0:    seq_err = ph_ev[0] | ph_ev[2];
            2'd1:    seq_err = ph_ev[1] | ph_ev[0];
            default: seq_err = ph_ev[2] | ph_ev[1];
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (reset || sv_q != MFS_SV_MON) begin
         last_q   <= 2'd0;
         last_v_q <= 1'b0;
      end else if (ph_ev != 3'b000) begin
         last_v_q <= 1'b1;
         last_q   <= ph_ev[2] ? 2'd2 : (ph_ev[1] ? 2'd1 : 2'd0);
      end
   end

   // fault detection
   always_comb begin
      det = '0;
      det[`MFS_B_OVL]   = acc_q > 32'(thermal_class) * OVL_K;
      det[`MFS_B_SC]    = ~s2_q[3] & sc_over;
      det[`MFS_B_STO]   = ramp_ms_q > 18'(ramp_time_s) * `MFS_S_TO_MS;
      det[`MFS_B_STALL] = run_state != MFS_RUN_FULL & over2;
      det[`MFS_B_OC]    = oc_ms_q > `MFS_OC_MS;
      det[`MFS_B_SEQ]   = seq_err;
      det[`MFS_B_UV]    = ctrl_supply_vac < `MFS_UV_VAC;
      det[`MFS_B_BYP]   = run_state == MFS_RUN_FULL & bypass_fail;
      det[`MFS_B_PBOC]  = run_state == MFS_RUN_RAMP & imax > pb_lim;
      det[`MFS_B_FREQ]  = line_freq < `MFS_F_LO | line_freq > `MFS_F_HI;
      det[`MFS_B_SHORT] = run_fall & no_volt_diff;
   end

   // lowest bit wins when several appear together
   localparam mfs_code_e CODES [NF] = '{MFS_F_OVL, MFS_F_SC, MFS_F_STO,
      MFS_F_STALL, MFS_F_OC, MFS_F_SEQ, MFS_F_UV, MFS_F_BYP, MFS_F_PBOC,
      MFS_F_FREQ, MFS_F_SHORT};
   always_comb begin
      code_d = MFS_F_NONE;
      for (int i = NF - 1; i >= 0; i--) begin
         if (det[i]) begin
            code_d = CODES[i];
         end
      end
   end

   // clear sources; auto reset only while a status bit of a fault that allows it is set
   assign clr = key_rise | prog_rise |
                (s2_q[2] & (auto_ms_q == `MFS_AUTO_MS) &
                 |(AUTO_OK & sts_q));

   always_ff @(posedge clk) begin
      if (reset) begin
         sv_q   <= MFS_SV_INIT;
         code_q <= MFS_F_NONE;
      end else begin
         case (sv_q)
            MFS_SV_INIT: begin
               if (nv_rd_valid) begin
                  sv_q <= MFS_SV_MON;
               end
            end
            MFS_SV_MON: begin
               if (det != '0) begin
                  sv_q   <= MFS_SV_TRIP;
                  code_q <= code_d;
               end
            end
            MFS_SV_TRIP: begin
               if (clr) begin
                  sv_q   <= MFS_SV_MON;
                  code_q <= MFS_F_NONE;
               end
            end
            default: sv_q <= MFS_SV_INIT;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         starter_enable <= 1'b0;
      end else begin
         starter_enable <= sv_q == MFS_SV_MON && det == '0 && !swblk_q;
      end
   end
   assign fault_code = code_q;

   // registers: status is write one to clear, a new event wins
   always_ff @(posedge clk) begin
      if (reset) begin
         sts_q   <= '0;
         mask_q  <= `MFS_MASK_RST;
         swblk_q <= `MFS_CTRL_RST;
      end else begin
         sts_q <= (sts_q & ~((wr_en && addr == `MFS_REG_STATUS) ?
                             wr_data[NF-1:0] : '0)) |
                  (det & {NF{sv_q == MFS_SV_MON}});
         if (wr_en && addr == `MFS_REG_MASK) begin
            mask_q <= wr_data[NF-1:0];
         end
         if (wr_en && addr == `MFS_REG_CTRL) begin
            swblk_q <= wr_data[`MFS_B_SWBLK];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset || !rd_en) begin
         rd_data <= 32'h00000000;
      end else begin
         case (addr)
            `MFS_REG_STATUS: rd_data <= {21'h0, sts_q};
            `MFS_REG_MASK:   rd_data <= {21'h0, mask_q};
            `MFS_REG_CODE:   rd_data <= {23'h0, sv_q == MFS_SV_TRIP, code_q};
            `MFS_REG_CTRL:   rd_data <= {31'h0, swblk_q};
            default:         rd_data <= 32'h00000000;
         endcase
      end
   end
   assign irq = |(sts_q & mask_q);

   // led patterns
   assign lk.tick    = tick;
   assign lk.tripped = sv_q == MFS_SV_TRIP;
   assign lk.ready   = sv_q == MFS_SV_MON;
   assign lk.code    = code_q;
   mfs_led u_led (
      .clk   (clk),
      .reset (reset),
      .lk    (lk)
   );
   assign fault_led       = lk.fault_led;
   assign ready_led       = lk.ready_led;
   assign overload_led    = lk.overload_led;
   assign stall_led       = lk.stall_led;
   assign overcurrent_led = lk.overcurrent_led;
   assign phase_seq_led   = lk.phase_seq_led;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   property p_block;
      sv_q == MFS_SV_TRIP |=> !starter_enable;
   endproperty
   a_block: assert property (p_block) else $error("run while tripped");
   property p_first;
      sv_q == MFS_SV_TRIP && !clr |=> code_q == $past(code_q);
   endproperty
   a_first: assert property (p_first) else $error("code changed");
   property p_sc;
      sv_q == MFS_SV_MON && !s2_q[3] && sc_over |=> sv_q == MFS_SV_TRIP;
   endproperty
   a_sc: assert property (p_sc) else $error("short missed");
   property p_stall;
      sv_q == MFS_SV_MON && run_state == MFS_RUN_RAMP && over2
         |=> sv_q == MFS_SV_TRIP;
   endproperty
   a_stall: assert property (p_stall) else $error("stall missed");
   property p_uv;
      sv_q == MFS_SV_MON && ctrl_supply_vac < 9'd93 && det[5:0] == 6'h00
         |=> code_q == MFS_F_UV;
   endproperty
   a_uv: assert property (p_uv) else $error("uv code missed");
   property p_freq;
      sv_q == MFS_SV_MON && (line_freq > 10'd660 || line_freq < 10'd450)
         |=> sv_q == MFS_SV_TRIP;
   endproperty
   a_freq: assert property (p_freq) else $error("freq missed");
   property p_noauto;
      sv_q == MFS_SV_TRIP && (code_q == MFS_F_SEQ || code_q == MFS_F_SC)
         && !key_rise && !prog_rise |=> sv_q == MFS_SV_TRIP;
   endproperty
   a_noauto: assert property (p_noauto) else $error("auto cleared");
   property p_save;
      pwr_fall |=> nv_wr_en && nv_wr_data == $past(acc_q);
   endproperty
   a_save: assert property (p_save) else $error("state not saved");
   property p_clear;
      sv_q == MFS_SV_TRIP && key_rise
         |=> sv_q == MFS_SV_MON && code_q == MFS_F_NONE;
   endproperty
   a_clear: assert property (p_clear) else $error("key clear missed");
endmodule

// ===== sim/mfs_net_model.sv
// supply network and measurement side model of the fault supervisor
module mfs_net_model (
   // clock
   input  wire logic        clk,
   // sync generator control
   input  wire logic        run,
   input  wire logic        rev,
   // synchronism interruptions
   output logic             sync_r,
   output logic             sync_s,
   output logic             sync_t,
   // thermal store
   input  wire logic        nv_wr_en,
   input  wire logic [31:0] nv_wr_data,
   output logic      [31:0] nv_rd_data,
   output logic             nv_rd_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]  ph_q = 2'h0;
   logic [4:0]  cnt_q = 5'h00;
   logic [31:0] st_q = 32'h0;
   // phase kept across pauses so a restart continues the rotation
   always_ff @(posedge clk) begin
      if (run)
         cnt_q <= cnt_q + 5'h01;
      if (run && cnt_q == 5'h1f)
         ph_q <= rev ? (ph_q == 2'h0 ? 2'h2 : ph_q - 2'h1)
                     : (ph_q == 2'h2 ? 2'h0 : ph_q + 2'h1);
   end
   // lines rest low between interruptions
   assign sync_r = run && ph_q == 2'h0 && cnt_q < 5'h08;
   assign sync_s = run && ph_q == 2'h1 && cnt_q < 5'h08;
   assign sync_t = run && ph_q == 2'h2 && cnt_q < 5'h08;
   always_ff @(posedge clk) begin
      if (nv_wr_en)
         st_q <= nv_wr_data;
   end
   assign nv_rd_data  = st_q;
   assign nv_rd_valid = 1'b1;
endmodule

// ===== sim/testbench.sv
// self-checking testbench of the motor starter fault supervisor
`include "mfs_defs.svh"
module testbench
   import mfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
   logic        reset_key = 1'b0, programmable_reset_input = 1'b0;
   logic        auto_reset_sw = 1'b0, ctrl_power_ok = 1'b1;
   logic        net_run = 1'b0, net_rev = 1'b0, run_cmd, irq, sync_r;
   logic        sync_s, sync_t, current_limit_mode, bypass_fail;
   logic        no_volt_diff, nv_wr_en, nv_rd_valid, starter_enable;
   logic        fault_led, ready_led;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wr_data = 32'h0, rd_data, nv_wr_data, nv_rd_data;
   logic [15:0] i_phase_r, i_phase_s, i_phase_t, i_rated, i_motor_set;
   logic [2:0]  model_sel;
   logic [4:0]  thermal_class;
   logic [7:0]  ramp_time_s, fault_code;
   logic [8:0]  ctrl_supply_vac;
   logic [9:0]  line_freq;
   mfs_run_e    run_state;
   int          n_fail = 0, num_checks = 0;

   always #5 clk = ~clk;

   // 1 ms tick shortened to ten cycles
   mfs_supervisor #(.TICK_CYC(17'h0000a)) mfs_supervisor_i (
      .clk, .reset, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .irq,
      .reset_key, .programmable_reset_input, .auto_reset_sw, .run_cmd,
      .sync_r, .sync_s, .sync_t, .ctrl_power_ok, .i_phase_r, .i_phase_s,
      .i_phase_t, .i_rated, .i_motor_set, .model_sel, .thermal_class,
      .ramp_time_s, .current_limit_mode, .run_state, .ctrl_supply_vac,
      .line_freq, .bypass_fail, .no_volt_diff, .nv_wr_en, .nv_wr_data,
      .nv_rd_data, .nv_rd_valid, .starter_enable, .fault_code, .fault_led,
      .ready_led, .overload_led(), .stall_led(), .overcurrent_led(),
      .phase_seq_led());
   mfs_net_model mfs_net_model_i (.clk, .run(net_run), .rev(net_rev),
      .sync_r, .sync_s, .sync_t, .nv_wr_en, .nv_wr_data, .nv_rd_data,
      .nv_rd_valid);

   task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wt(int n);
      for (int i = 0; i < n && fault_code === 8'h00; i++)
         @(posedge clk);
   endtask
   task automatic fc(logic [7:0] e);
      chk("fault_code", 32'(fault_code), 32'(e));
   endtask
   // run command settles before any current so no stopped short is seen
   task automatic go(mfs_run_e st);
      run_cmd <= 1'b1;
      run_state <= st;
      cyc(4);
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk("rd_data", rd_data, e);
      @(posedge clk);
   endtask
   // every measurement back to a healthy stopped motor
   task automatic idle();
      {run_cmd, current_limit_mode, bypass_fail, no_volt_diff} <= 4'h0;
      {i_phase_r, i_phase_s, i_phase_t} <= 48'h0;
      {i_rated, i_motor_set} <= {2{16'h3e8}};
      model_sel <= 3'h0;
      thermal_class <= 5'h1f;
      ramp_time_s <= 8'h01;
      run_state <= MFS_RUN_STOP;
      ctrl_supply_vac <= 9'h078;
      line_freq <= 10'h258;
   endtask
   task automatic clr(logic prog);
      idle();
      cyc(4);
      if (prog)
         programmable_reset_input <= 1'b1;
      else
         reset_key <= 1'b1;
      cyc(6);
      reset_key <= 1'b0;
      programmable_reset_input <= 1'b0;
      cyc(6);
      fc(8'h00);
   endtask
   task automatic por();
      reset <= 1'b1;
      idle();
      cyc(16);
      reset <= 1'b0;
      for (int i = 0; i < 50 && starter_enable !== 1'b1; i++)
         @(posedge clk);
      chk("starter_enable", 32'(starter_enable), 32'h1);
   endtask
   task automatic probe(logic [7:0] e, logic rdy, logic cl);
      wt(40);
      cyc(30);
      fc(e);
      chk("starter_enable", 32'(starter_enable), 32'(e == 8'h00));
      chk("ready_led", 32'(ready_led), 32'(rdy));
      if (cl && e != 8'h00)
         clr(1'b0);
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic t_uv();
      wr(`MFS_REG_MASK, 32'h40);
      ctrl_supply_vac <= 9'h05d;
      probe(8'h00, 1'b1, 1'b0);
      ctrl_supply_vac <= 9'h05c;
      probe(MFS_F_UV, 1'b0, 1'b0);
      chk("irq", 32'(irq), 32'h1);
      rd(`MFS_REG_STATUS, 32'h40);
      for (int i = 0; i < 3000 && fault_led !== 1'b1; i++)
         @(posedge clk);
      chk("fault_led", 32'(fault_led), 32'h1);
      ctrl_supply_vac <= 9'h078;
      auto_reset_sw <= 1'b1;
      for (int i = 0; i < 12000 && fault_code !== 8'h00; i++)
         @(posedge clk);
      fc(8'h00);
      auto_reset_sw <= 1'b0;
      wr(`MFS_REG_STATUS, 32'h40);
      rd(`MFS_REG_STATUS, 32'h0);
      chk("irq", 32'(irq), 32'h0);
   endtask
   task automatic t_sc();
      i_phase_s <= 16'h12c;
      probe(8'h00, 1'b1, 1'b0);
      i_phase_s <= 16'h12d;
      probe(MFS_F_SC, 1'b0, 1'b0);
      chk("irq", 32'(irq), 32'h0);
      ctrl_supply_vac <= 9'h05c;
      auto_reset_sw <= 1'b1;
      cyc(12000);
      fc(MFS_F_SC);
      auto_reset_sw <= 1'b0;
      clr(1'b1);
   endtask
   task automatic t_freq();
      logic [9:0] f [4] = '{10'h1c2, 10'h294, 10'h1c1, 10'h295};
      for (int k = 0; k < 4; k++) begin
         line_freq <= f[k];
         probe(k < 2 ? 8'h00 : MFS_F_FREQ, k < 2, 1'b1);
      end
   endtask
   task automatic t_stall_oc();
      go(MFS_RUN_PREBYP);
      i_phase_t <= 16'h7d0;
      probe(8'h00, 1'b1, 1'b0);
      i_phase_t <= 16'h7d1;
      probe(MFS_F_STALL, 1'b0, 1'b1);
      // small setting keeps the thermal model far from its limit
      go(MFS_RUN_FULL);
      i_motor_set <= 16'h000a;
      i_phase_r <= 16'h0015;
      cyc(9000);
      fc(8'h00);
      wt(2500);
      probe(MFS_F_OC, 1'b0, 1'b1);
   endtask
   task automatic t_pbo();
      logic [15:0] lim [5] = '{`MFS_PB_LIM0, `MFS_PB_LIM1, `MFS_PB_LIM2,
                              `MFS_PB_LIM3, `MFS_PB_LIM4};
      for (int m = 0; m < 5; m++) begin
         go(MFS_RUN_RAMP);
         model_sel <= 3'(m);
         i_motor_set <= lim[m];
         i_phase_r <= lim[m];
         probe(8'h00, 1'b1, 1'b0);
         i_phase_r <= lim[m] + 16'h1;
         probe(MFS_F_PBOC, 1'b0, 1'b1);
      end
   endtask
   task automatic t_byp_e77();
      go(MFS_RUN_RAMP);
      bypass_fail <= 1'b1;
      probe(8'h00, 1'b1, 1'b0);
      run_state <= MFS_RUN_FULL;
      probe(MFS_F_BYP, 1'b0, 1'b1);
      run_cmd <= 1'b1;
      no_volt_diff <= 1'b1;
      probe(8'h00, 1'b1, 1'b0);
      run_cmd <= 1'b0;
      probe(MFS_F_SHORT, 1'b0, 1'b1);
   endtask
   task automatic t_sto();
      go(MFS_RUN_RAMP);
      cyc(12000);
      fc(8'h00);
      idle();
      cyc(2);
      go(MFS_RUN_RAMP);
      current_limit_mode <= 1'b1;
      cyc(9000);
      fc(8'h00);
      wt(3000);
      probe(MFS_F_STO, 1'b1, 1'b1);
   endtask
   task automatic t_seq();
      net_run <= 1'b1;
      cyc(400);
      fc(8'h00);
      net_rev <= 1'b1;
      wt(200);
      net_run <= 1'b0;
      probe(MFS_F_SEQ, 1'b0, 1'b1);
      net_rev <= 1'b0;
   endtask
   // last: the thermal state survives the power cycles below
   task automatic t_ovl();
      por();
      thermal_class <= 5'h01;
      go(MFS_RUN_FULL);
      i_phase_r <= 16'h7cf;
      cyc(500);
      fc(8'h00);
      wt(1500);
      probe(MFS_F_OVL, 1'b0, 1'b0);
      ctrl_power_ok <= 1'b0;
      for (int i = 0; i < 10 && nv_wr_en !== 1'b1; i++)
         @(posedge clk);
      chk("nv_wr_en", 32'(nv_wr_en), 32'h1);
      ctrl_power_ok <= 1'b1;
      por();
      thermal_class <= 5'h01;
      go(MFS_RUN_FULL);
      i_phase_r <= 16'h3f2;
      wt(200);
      probe(MFS_F_OVL, 1'b0, 1'b0);
   endtask

   initial begin
      por();
      rd(`MFS_REG_MASK, 32'h0);
      rd(4'h2, 32'h0);
      rd(`MFS_REG_CODE, 32'h0);
      t_uv();
      t_sc();
      t_freq();
      t_stall_oc();
      t_pbo();
      t_byp_e77();
      t_sto();
      t_seq();
      t_ovl();
      end_sim();
   end
   initial begin
      #900000;
      n_fail++;
      end_sim();
   end
endmodule
